// ---- dv/artc_core_model.sv ----
`timescale 1ns/100ps
module artc_core_model (
  input wire clk_i,
  input wire rst_i,
  input wire start_i,
  input wire enable_i,
  input wire [9:0] value_i,
  output reg done_o,
  output wire [9:0] result_o
);
  reg [2:0] cnt_reg;
  // Outside the done cycle the result is inverted, so a load taken on the
  // wrong cycle shows up as a wrong value.
  assign result_o = done_o ? value_i : ~value_i;
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    if (rst_i || !enable_i) begin
      cnt_reg <= 3'h0;
    end else if (start_i) begin
      cnt_reg <= 3'h4;
    end else if (cnt_reg != 3'h0) begin
      cnt_reg <= cnt_reg - 3'h1;
      done_o <= (cnt_reg == 3'h1);
    end
  end
endmodule // artc_core_model

// ---- dv/artc_ctrl_assertions.sv ----
`timescale 1ns/100ps
module artc_ctrl_assertions (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [9:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire conv_enable_o,
  input wire conv_start_o,
  input wire conv_busy_o,
  input wire conv_done_i,
  input wire done_flag_o,
  input wire [5:0] buffer_off_o,
  input wire [5:0] port_pin_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire rd = req & ~wb_we_i;
  wire wr = req & wb_we_i & wb_sel_i[0];
  wire [7:0] idx = wb_adr_i[9:2];
  a_ack_next: assert property (req |=> wb_ack_o)
    else $error("access not answered in one cycle");
  a_trig_rsvd: assert property (rd && idx == 8'h7b |=>
    (wb_dat_o[7:0] & 8'hb8) == 8'h00) else $error("trigger reserved set");
  a_pin_rsvd: assert property (rd && idx == 8'h7e |=>
    wb_dat_o[7:6] == 2'h0) else $error("disable reserved bits set");
  a_pin_write: assert property (wr && idx == 8'h7e |=>
    buffer_off_o == $past(wb_dat_i[5:0])) else $error("disable not stored");
  a_pin_mask: assert property ((port_pin_o & buffer_off_o) == 6'h00)
    else $error("disabled pin reads one");
  a_start_enabled: assert property (conv_start_o |->
    conv_enable_o && conv_busy_o) else $error("start while disabled");
  a_start_pulse: assert property (conv_start_o |=> !conv_start_o)
    else $error("start longer than one cycle");
  a_done_cause: assert property ($rose(done_flag_o) |->
    $past(conv_done_i & conv_busy_o)) else $error("flag without completion");
  a_flag_clear: assert property (wr && idx == 8'h7a && wb_dat_i[4] &&
    !conv_busy_o |=> !done_flag_o) else $error("flag not cleared");
  a_busy_end: assert property (conv_busy_o && conv_done_i |=>
    !conv_busy_o) else $error("busy after completion");
  c_start: cover property (conv_start_o);
  c_flag: cover property ($rose(done_flag_o));
  c_pin_wr: cover property (wr && idx == 8'h7e);
endmodule // artc_ctrl_assertions

bind artc_ctrl artc_ctrl_assertions u_chk (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .conv_enable_o, .conv_start_o, .conv_busy_o, .conv_done_i, .done_flag_o,
  .buffer_off_o, .port_pin_o);

// ---- dv/artc_ctrl_tb.sv ----
`timescale 1ns/100ps
module artc_ctrl_tb;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0;
  logic ack, done, cdone, busy, start, en, cmux;
  logic [9:0] adr = 0, cres, val = 0;
  logic [31:0] wdat = 0, rdat;
  logic [7:0] rv;
  logic [6:0] flags = 0;
  logic [5:0] pin = 0, pout, boff;
  logic [3:0] chan;
  integer n_fail = 0, check_count = 0, n_start = 0, cycles = 0;
  always #5 clk = ~clk;
  artc_ctrl u_dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .conv_enable_o(en),
    .conv_start_o(start), .conv_channel_o(chan), .conv_busy_o(busy),
    .conv_done_i(cdone), .conv_result_i(cres), .trig_flags_i(flags),
    .comparator_mux_enable_o(cmux), .done_flag_o(done),
    .buffer_off_o(boff), .port_pin_i(pin), .port_pin_o(pout));
  artc_core_model u_core (.clk_i(clk), .rst_i(rst), .start_i(start),
    .enable_i(en), .value_i(val), .done_o(cdone), .result_o(cres));
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (start) n_start <= n_start + 1;
    if (cycles == 20000) begin
      n_fail = n_fail + 1;
      stop_test;
    end
  end
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task chk(input string n, input [31:0] s, input [31:0] e);
    begin
      check_count = check_count + 1;
      if (s !== e) begin
        n_fail = n_fail + 1;
        $display("ERROR %s expected %h seen %h", n, e, s);
      end
    end
  endtask
  task bus(input [9:0] a, input w, input [7:0] d);
    begin
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, d};
      @(posedge clk);
      while (ack !== 1'b1) @(posedge clk);
      rv = rdat[7:0];
      cyc <= 0;
      stb <= 0;
      @(posedge clk);
    end
  endtask
  task rc(input [9:0] a, input [7:0] e);
    begin
      bus(a, 0, 0);
      chk($sformatf("reg %h", a), rv, e);
    end
  endtask
  task conv(input [9:0] v);
    begin
      val <= v;
      bus(10'h1e8, 1, 8'hc0);
      @(posedge clk iff cdone);
      repeat (2) @(posedge clk);
    end
  endtask
  task t_reset;
    begin
      rc(10'h1e0, 8'h00);
      rc(10'h1e4, 8'h00);
      rc(10'h1ec, 8'h00);
      rc(10'h1f8, 8'h00);
      rc(10'h3fc, 8'h00);
    end
  endtask
  task t_adjust;
    begin
      conv(10'h2d7);
      chk("flag", done, 1);
      bus(10'h1e0, 1, 8'hff);
      rc(10'h1e0, 8'hd7);
      rc(10'h1e4, 8'h02);
      bus(10'h1f0, 1, 8'h23);
      chk("channel", chan, 4'h3);
      rc(10'h1f0, 8'h23);
      rc(10'h1e0, 8'hc0);
      rc(10'h1e4, 8'hb5);
      bus(10'h1f0, 1, 8'h00);
      bus(10'h1e8, 1, 8'h90);
      chk("flag", done, 0);
    end
  endtask
  task t_lock;
    begin
      rc(10'h1e0, 8'hd7);
      conv(10'h155);
      chk("flag", done, 0);
      chk("enable", en, 1);
      chk("busy", busy, 0);
      rc(10'h1e4, 8'h02);
      conv(10'h155);
      rc(10'h1e0, 8'h55);
      rc(10'h1e4, 8'h01);
      bus(10'h1e8, 1, 8'h90);
    end
  endtask
  task t_trig;
    integer s, k;
    begin
      for (s = 1; s < 8; s = s + 1) begin
        bus(10'h1ec, 1, s[7:0]);
        bus(10'h1e8, 1, 8'hb0);
        k = n_start;
        flags <= 7'h01 << (s - 1);
        @(posedge clk iff cdone);
        repeat (2) @(posedge clk);
        flags <= 7'h00;
        chk("src start", n_start, k + 1);
      end
      bus(10'h1e8, 1, 8'h90);
      k = n_start;
      flags <= 7'h7f;
      repeat (4) @(posedge clk);
      chk("auto off", n_start, k);
      flags <= 7'h08;
      bus(10'h1ec, 1, 8'h03);
      bus(10'h1e8, 1, 8'ha0);
      k = n_start;
      bus(10'h1ec, 1, 8'h04);
      @(posedge clk iff cdone);
      repeat (2) @(posedge clk);
      chk("switch", n_start, k + 1);
      flags <= 7'h00;
      k = n_start;
      bus(10'h1ec, 1, 8'h00);
      repeat (4) @(posedge clk);
      chk("free run", n_start, k);
      bus(10'h1e8, 1, 8'h90);
    end
  endtask
  task t_pins;
    begin
      pin <= 6'h3f;
      bus(10'h1f8, 1, 8'hff);
      rc(10'h1f8, 8'h3f);
      bus(10'h1f8, 1, 8'h15);
      @(posedge clk);
      chk("pin read", pout, 6'h2a);
      chk("buffer off", boff, 6'h15);
      bus(10'h1ec, 1, 8'hff);
      rc(10'h1ec, 8'h47);
      chk("cmp mux", cmux, 1);
    end
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    t_reset;
    t_adjust;
    t_lock;
    t_trig;
    t_pins;
    stop_test;
  end
endmodule // artc_ctrl_tb

// ---- logic/artc_ctrl.v ----
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/100ps
`include "artc_defines.vh"

module artc_ctrl (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [9:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  output wire conv_enable_o,
  output wire conv_start_o,
  output wire [3:0] conv_channel_o,
  output wire conv_busy_o,
  input wire conv_done_i,
  input wire [9:0] conv_result_i,
  input wire [6:0] trig_flags_i,
  output wire comparator_mux_enable_o,
  output wire done_flag_o,
  output wire [5:0] buffer_off_o,
  input wire [5:0] port_pin_i,
  output wire [5:0] port_pin_o
);

  // Bus interface state.
  reg ack_reg;
  reg [31:0] rdata_reg;
  reg [31:0] rdata_next;
  wire req;
  wire [7:0] index;
  wire wr_lane0;

  // Register contents.
  reg [9:0] result_reg;
  reg [9:0] result_next;
  reg lock_reg;
  reg lock_next;
  reg enable_reg;
  reg enable_next;
  reg auto_reg;
  reg auto_next;
  reg done_reg;
  reg done_next;
  reg busy_reg;
  reg busy_next;
  reg cmp_mux_reg;
  reg cmp_mux_next;
  reg [2:0] src_reg;
  reg [2:0] src_next;
  reg left_reg;
  reg left_next;
  reg [3:0] chan_reg;
  reg [3:0] chan_next;
  reg [5:0] pin_off_reg;
  reg [5:0] pin_off_next;
  reg [5:0] pin_rd_reg;
  reg start_reg;

  // Presented result bytes.
  reg [7:0] low_byte;
  reg [7:0] high_byte;

  // Decoded accesses.
  wire rd_low;
  wire rd_high;
  wire wr_ctrl;
  wire wr_trig;
  wire wr_chan;
  wire wr_pins;

  // Conversion sequencing.
  wire accept_done;
  wire load_result;
  wire sw_start;
  wire trig_edge;
  wire start_req;
  wire [7:0] trig_levels;

  assign req = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign index = wb_adr_i[9:2];
  assign wr_lane0 = req & wb_we_i & wb_sel_i[0];

  assign rd_low = req & ~wb_we_i & (index == `ARTC_IDX_RESULT_LOW);
  assign rd_high = req & ~wb_we_i & (index == `ARTC_IDX_RESULT_HIGH);
  assign wr_ctrl = wr_lane0 & (index == `ARTC_IDX_CONVERT_CTRL);
  assign wr_trig = wr_lane0 & (index == `ARTC_IDX_TRIGGER_SEL);
  assign wr_chan = wr_lane0 & (index == `ARTC_IDX_CHANNEL_CFG);
  assign wr_pins = wr_lane0 & (index == `ARTC_IDX_PIN_DISABLE);

  // Byte presentation follows the live left-adjust bit, so a change shows
  // up on the very next read even mid-conversion. [RULE_19]
  always @* begin
    if (left_reg) begin
      high_byte = result_reg[9:2]; // [RULE_03]
      low_byte = {result_reg[1:0], 6'h00}; // [RULE_03]
    end else begin
      high_byte = {6'h00, result_reg[9:8]}; // [RULE_02]
      low_byte = result_reg[7:0]; // [RULE_02]
    end
  end

  // Free running uses the done flag as its trigger level.
  assign trig_levels = {trig_flags_i, done_reg}; // [RULE_05]

  artc_trig_sel u_trig_sel (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sel_i(src_reg),
    .flags_i(trig_levels),
    .edge_o(trig_edge)
  );

  // A completion that arrives when nothing was started is ignored.
  assign accept_done = conv_done_i & busy_reg;

  // A low-byte read in the same cycle as a completion already froze the
  // bytes, so the new result is dropped then as well. [RULE_20]
  assign load_result = accept_done & ~lock_reg & ~rd_low; // [RULE_01]

  assign sw_start = wr_ctrl & wb_dat_i[`ARTC_CC_START_BIT] &
                    wb_dat_i[`ARTC_CC_ENABLE_BIT];

  // The selected edge matters only while auto-triggering is on. [RULE_06]
  assign start_req = enable_next & ~busy_reg &
                     (sw_start | (auto_reg & trig_edge)); // [RULE_17]

  always @* begin
    result_next = result_reg;
    if (load_result) begin
      result_next = conv_result_i; // [RULE_15]
    end
  end

  always @* begin
    lock_next = lock_reg;
    if (rd_low) begin
      lock_next = 1'b1; // [RULE_01]
    end else if (rd_high) begin
      lock_next = 1'b0; // [RULE_01]
    end
  end

  always @* begin
    enable_next = enable_reg;
    auto_next = auto_reg;
    if (wr_ctrl) begin
      enable_next = wb_dat_i[`ARTC_CC_ENABLE_BIT];
      auto_next = wb_dat_i[`ARTC_CC_AUTO_BIT]; // [RULE_17]
    end
  end

  // Writing one clears the flag, but a completion in the same cycle wins.
  always @* begin
    done_next = done_reg;
    if (wr_ctrl && wb_dat_i[`ARTC_CC_DONE_BIT]) begin
      done_next = 1'b0; // [RULE_18]
    end
    if (load_result) begin
      done_next = 1'b1; // [RULE_18]
    end
  end

  // Turning the converter off abandons a conversion in progress.
  always @* begin
    busy_next = busy_reg;
    if (!enable_next) begin
      busy_next = 1'b0;
    end else if (start_req) begin
      busy_next = 1'b1;
    end else if (accept_done) begin
      busy_next = 1'b0;
    end
  end

  // Reserved bits are never stored, so they read back as zero.
  always @* begin
    cmp_mux_next = cmp_mux_reg;
    src_next = src_reg;
    if (wr_trig) begin
      cmp_mux_next = wb_dat_i[`ARTC_TS_CMP_MUX_BIT];
      src_next = wb_dat_i[`ARTC_TS_SRC_HI:`ARTC_TS_SRC_LO]; // [RULE_05]
    end
  end

  always @* begin
    left_next = left_reg;
    chan_next = chan_reg;
    if (wr_chan) begin
      left_next = wb_dat_i[`ARTC_CH_LEFT_BIT]; // [RULE_19]
      chan_next = wb_dat_i[`ARTC_CH_SEL_HI:`ARTC_CH_SEL_LO];
    end
  end

  // Only pins 0 to 5 have buffers to switch off. [RULE_14]
  always @* begin
    pin_off_next = pin_off_reg;
    if (wr_pins) begin
      pin_off_next = wb_dat_i[`ARTC_PIN_COUNT-1:0]; // [RULE_11]
    end
  end

  // Read data mux; unmapped words answer with zero.
  always @* begin
    rdata_next = 32'h00000000;
    if (index == `ARTC_IDX_RESULT_LOW) begin
      rdata_next[7:0] = low_byte;
    end else if (index == `ARTC_IDX_RESULT_HIGH) begin
      rdata_next[7:0] = high_byte;
    end else if (index == `ARTC_IDX_CONVERT_CTRL) begin
      rdata_next[`ARTC_CC_ENABLE_BIT] = enable_reg;
      rdata_next[`ARTC_CC_START_BIT] = busy_reg;
      rdata_next[`ARTC_CC_AUTO_BIT] = auto_reg;
      rdata_next[`ARTC_CC_DONE_BIT] = done_reg;
    end else if (index == `ARTC_IDX_TRIGGER_SEL) begin
      rdata_next[`ARTC_TS_CMP_MUX_BIT] = cmp_mux_reg; // [RULE_10]
      rdata_next[`ARTC_TS_SRC_HI:`ARTC_TS_SRC_LO] = src_reg;
    end else if (index == `ARTC_IDX_CHANNEL_CFG) begin
      rdata_next[`ARTC_CH_LEFT_BIT] = left_reg;
      rdata_next[`ARTC_CH_SEL_HI:`ARTC_CH_SEL_LO] = chan_reg;
    end else if (index == `ARTC_IDX_PIN_DISABLE) begin
      rdata_next[`ARTC_PIN_COUNT-1:0] = pin_off_reg; // [RULE_13]
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      ack_reg <= req;
      if (req && !wb_we_i) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      result_reg <= `ARTC_RST_RESULT; // [RULE_15]
      lock_reg <= 1'b0;
      enable_reg <= 1'b0;
      auto_reg <= 1'b0;
      done_reg <= 1'b0;
      busy_reg <= 1'b0;
      start_reg <= 1'b0;
    end else begin
      result_reg <= result_next;
      lock_reg <= lock_next;
      enable_reg <= enable_next;
      auto_reg <= auto_next;
      done_reg <= done_next;
      busy_reg <= busy_next;
      start_reg <= start_req;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      cmp_mux_reg <= 1'b0;
      src_reg <= `ARTC_RST_SRC;
      left_reg <= 1'b0;
      chan_reg <= `ARTC_RST_CHAN;
      pin_off_reg <= `ARTC_RST_PINS;
    end else begin
      cmp_mux_reg <= cmp_mux_next;
      src_reg <= src_next;
      left_reg <= left_next;
      chan_reg <= chan_next;
      pin_off_reg <= pin_off_next;
    end
  end

  // The pin value is registered, so it lags the pad by one cycle.
  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_rd_reg <= `ARTC_RST_PINS;
    end else begin
      pin_rd_reg <= port_pin_i & ~pin_off_next; // [RULE_12]
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;
  assign conv_enable_o = enable_reg;
  assign conv_start_o = start_reg;
  assign conv_channel_o = chan_reg;
  assign conv_busy_o = busy_reg;
  assign comparator_mux_enable_o = cmp_mux_reg;
  assign done_flag_o = done_reg;
  assign buffer_off_o = pin_off_reg; // [RULE_11]
  assign port_pin_o = pin_rd_reg;

endmodule // artc_ctrl

// ---- logic/artc_defines.vh ----
// Overview of operation
// (RULE_01) Reading the low byte freezes both result bytes until the high byte is read.
// (RULE_02) Right-adjusted: low byte holds bits 7..0, high byte bits 1..0 hold 9..8.
// (RULE_03) Left-adjusted: high byte holds bits 9..2, low byte bits 7..6 hold 1..0.
// (RULE_04) Software reads low byte first; high byte alone suffices for 8-bit left-adjusted.
// (RULE_05) Trigger source codes 0..7 select free run, comparator, int0, timers.
// (RULE_06) With auto-trigger off the source field starts nothing.
// (RULE_07) With auto-trigger on, each rising edge of the selected flag starts a conversion; the code ignores an edge that comes while busy.
// (RULE_08) Switching from a clear source to a set source counts as a rising edge.
// (RULE_09) Switching the selection to free running never makes a trigger event.
// (RULE_10) Software writes zero to trigger control bits 7 and 5..3; they read zero.
// (RULE_11) Each of six disable bits turns off the input buffer of pin 0..5.
// (RULE_12) A disabled pin reads zero in the port pin-read value.
// (RULE_13) Software writes zero to input-disable bits 7..6; they read zero.
// (RULE_14) Analog pins 6 and 7 get no input-disable bits.
// (RULE_15) Result bytes load on conversion completion, are read-only and reset to zero.
// (RULE_16) Software should disable input buffers of pins carrying analog signals.
// (RULE_17) Setting auto-trigger enable allows hardware starts on the selected edge.
// (RULE_18) Done flag sets when the result updates; writing one clears it.
// (RULE_19) Changing left-adjust re-maps the presented bytes at once.
// (RULE_20) A result completing while frozen is discarded, not written.
`ifndef ARTC_DEFINES_VH
`define ARTC_DEFINES_VH

// Register indices; byte address is four times the index.
`define ARTC_IDX_RESULT_LOW 8'h78
`define ARTC_IDX_RESULT_HIGH 8'h79
`define ARTC_IDX_CONVERT_CTRL 8'h7a
`define ARTC_IDX_TRIGGER_SEL 8'h7b
`define ARTC_IDX_CHANNEL_CFG 8'h7c
`define ARTC_IDX_PIN_DISABLE 8'h7e

// Convert control fields.
`define ARTC_CC_ENABLE_BIT 7
`define ARTC_CC_START_BIT 6
`define ARTC_CC_AUTO_BIT 5
`define ARTC_CC_DONE_BIT 4

// Trigger select control fields.
`define ARTC_TS_CMP_MUX_BIT 6
`define ARTC_TS_SRC_HI 2
`define ARTC_TS_SRC_LO 0

// Channel configuration fields.
`define ARTC_CH_LEFT_BIT 5
`define ARTC_CH_SEL_HI 3
`define ARTC_CH_SEL_LO 0

// Pin input disable field width.
`define ARTC_PIN_COUNT 6

// Trigger source codes.
`define ARTC_SRC_FREE_RUN 3'h0
`define ARTC_SRC_COMPARATOR 3'h1
`define ARTC_SRC_EXT_INT0 3'h2
`define ARTC_SRC_T0_CMP_A 3'h3
`define ARTC_SRC_T0_OVF 3'h4
`define ARTC_SRC_T1_CMP_B 3'h5
`define ARTC_SRC_T1_OVF 3'h6
`define ARTC_SRC_T1_CAPTURE 3'h7

// Reset values.
`define ARTC_RST_RESULT 10'h000
`define ARTC_RST_BYTE 8'h00
`define ARTC_RST_SRC 3'h0
`define ARTC_RST_PINS 6'h00
`define ARTC_RST_CHAN 4'h0

`endif

// ---- logic/artc_trig_sel.v ----
`timescale 1ns/100ps
`include "artc_defines.vh"

module artc_trig_sel (
  input wire clk_i,
  input wire rst_i,
  input wire [2:0] sel_i,
  input wire [7:0] flags_i,
  output wire edge_o
);

  reg [2:0] sel_reg;
  reg level_reg;
  wire level_now;

  assign level_now = flags_i[sel_i];

  // The previous level is taken from whatever source was selected last,
  // so a switch onto a set flag reads as a rising edge. [RULE_08]
  // A switch onto free running is masked. [RULE_09]
  assign edge_o = level_now & ~level_reg &
                  ~((sel_i == `ARTC_SRC_FREE_RUN) &&
                    (sel_reg != `ARTC_SRC_FREE_RUN)); // [RULE_07]

  always @(posedge clk_i) begin
    if (rst_i) begin
      sel_reg <= `ARTC_RST_SRC;
      level_reg <= 1'b0;
    end else begin
      sel_reg <= sel_i;
      level_reg <= level_now;
    end
  end

endmodule // artc_trig_sel
